// File: jlla_defines.vh
// constants for the link layer alignment transmitter
`ifndef JLLA_DEFINES_VH
`define JLLA_DEFINES_VH
`define JLLA_LANES 2
`define JLLA_CFG_OCTETS 14
`define JLLA_K_R 8'h1c
`define JLLA_K_A 8'h7c
`define JLLA_K_Q 8'h9c
`define JLLA_K_K 8'hbc
`define JLLA_K_F 8'hfc
`define JLLA_D_F 8'hfc
`define JLLA_D_A 8'h7c
`define JLLA_ILAS_LAST 2'h3
`define JLLA_CFG_FIRST 11'h002
`define JLLA_CFG_END 11'h010
`define JLLA_MB_LAST 5'h1f
`define JLLA_SH_ONE 2'h2
`define JLLA_SH_ZERO 2'h1
`define JLLA_S8_TAP_A 14
`define JLLA_S8_TAP_B 13
`define JLLA_S64_TAP_A 57
`define JLLA_S64_TAP_B 38
`endif

// File: jlla_tx.v
// link layer alignment transmitter for 8b/10b and 64b/66b lanes
`timescale 1ns/1ps
`default_nettype none
`include "jlla_defines.vh"
module jlla_tx (
  input wire clk_sys,
  input wire rst_b,
  input wire sync_n,
  input wire sysref,
  input wire mode_64b,
  input wire scr_en,
  input wire fec_mode,
  input wire [8:0] f_cfg,
  input wire [8:0] k_cfg,
  input wire [7:0] e_cfg,
  input wire [8*`JLLA_CFG_OCTETS-1:0] cfg_params,
  input wire [64*`JLLA_LANES-1:0] data_in,
  input wire [26*`JLLA_LANES-1:0] parity_in,
  output wire data_ready,
  output wire [66*`JLLA_LANES-1:0] tx_word,
  output wire [`JLLA_LANES-1:0] tx_k,
  output wire mb_start,
  output wire link_up
);
  localparam ST_CGS = 4'h1;
  localparam ST_HOLD = 4'h2;
  localparam ST_ILAS = 4'h4;
  localparam ST_DATA = 4'h8;

  // reset release through two flops
  reg rst_m_q, rst_s_q;
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_m_q <= 1'b0;
      rst_s_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_s_q <= rst_m_q;
    end
  end
  wire rst_n = rst_s_q;

  // pin synchronisers
  reg snc_m_q, snc_s_q, snc_p_q, srf_m_q, srf_s_q, srf_p_q;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      snc_m_q <= 1'b0;
      snc_s_q <= 1'b0;
      snc_p_q <= 1'b0;
      srf_m_q <= 1'b0;
      srf_s_q <= 1'b0;
      srf_p_q <= 1'b0;
    end else begin
      snc_m_q <= sync_n;
      snc_s_q <= snc_m_q;
      snc_p_q <= snc_s_q;
      srf_m_q <= sysref;
      srf_s_q <= srf_m_q;
      srf_p_q <= srf_s_q;
    end
  end
  wire srf_edge = srf_s_q & ~srf_p_q;
  wire snc_rise = snc_s_q & ~snc_p_q;

  // local multiframe and extended multiblock counters
  reg [7:0] oct_q;
  reg [10:0] idx_q;
  reg [4:0] blk_q;
  reg [7:0] mb_q;
  wire [17:0] fk_w = f_cfg * k_cfg;
  wire frm_end = ({1'b0, oct_q} == f_cfg - 9'h001);
  wire mf_end = (idx_q == fk_w[10:0] - 11'h001);
  wire blk_last = (blk_q == `JLLA_MB_LAST);
  wire emb_last = (mb_q == e_cfg - 8'h01);
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      oct_q <= 8'h00;
      idx_q <= 11'h000;
      blk_q <= 5'h00;
      mb_q <= 8'h00;
    end else if (srf_edge) begin
      oct_q <= 8'h00;
      idx_q <= 11'h000;
      blk_q <= 5'h00;
      mb_q <= 8'h00;
    end else begin
      oct_q <= frm_end ? 8'h00 : oct_q + 8'h01;
      idx_q <= mf_end ? 11'h000 : idx_q + 11'h001;
      blk_q <= blk_q + 5'h01;
      if (blk_last)
        mb_q <= emb_last ? 8'h00 : mb_q + 8'h01;
    end
  end

  // 8b/10b link start-up sequence
  reg [3:0] st_q;
  reg [1:0] ilas_mf_q;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_CGS;
      ilas_mf_q <= 2'h0;
    end else if (!snc_s_q) begin
      st_q <= ST_CGS;
    end else begin
      case (st_q)
        ST_CGS: if (snc_rise) st_q <= ST_HOLD;
        ST_HOLD: if (mf_end) begin
          st_q <= ST_ILAS;
          ilas_mf_q <= 2'h0;
        end
        ST_ILAS: if (mf_end) begin
          if (ilas_mf_q == `JLLA_ILAS_LAST)
            st_q <= ST_DATA;
          ilas_mf_q <= ilas_mf_q + 2'h1;
        end
        ST_DATA: st_q <= ST_DATA;
        default: st_q <= ST_CGS;
      endcase
    end
  end

  // unscrambled alignment sequence content, shared by all lanes
  reg [7:0] ilas_oct;
  reg ilas_k;
  wire [3:0] cfg_j = idx_q[3:0] - 4'h2;
  always @* begin
    ilas_oct = idx_q[7:0];
    ilas_k = 1'b0;
    if (idx_q == 11'h000) begin
      ilas_oct = `JLLA_K_R;
      ilas_k = 1'b1;
    end else if (mf_end) begin
      ilas_oct = `JLLA_K_A;
      ilas_k = 1'b1;
    end else if (ilas_mf_q == 2'h1 && idx_q == 11'h001) begin
      ilas_oct = `JLLA_K_Q;
      ilas_k = 1'b1;
    end else if (ilas_mf_q == 2'h1 && idx_q >= `JLLA_CFG_FIRST && idx_q < `JLLA_CFG_END) begin
      ilas_oct = cfg_params[{cfg_j, 3'b000} +: 8];
    end
  end

  function [22:0] scr8;
    input [14:0] st;
    input [7:0] d;
    integer i;
    reg [14:0] s;
    reg b;
    begin
      s = st;
      scr8 = 23'h000000;
      for (i = 7; i >= 0; i = i - 1) begin
        b = d[i] ^ s[`JLLA_S8_TAP_A] ^ s[`JLLA_S8_TAP_B];
        scr8[i] = b;
        s = {s[13:0], b};
      end
      scr8[22:8] = s;
    end
  endfunction

  function [121:0] scr64;
    input [57:0] st;
    input [63:0] d;
    integer i;
    reg [57:0] s;
    reg b;
    begin
      s = st;
      scr64 = 122'h0;
      for (i = 63; i >= 0; i = i - 1) begin
        b = d[i] ^ s[`JLLA_S64_TAP_A] ^ s[`JLLA_S64_TAP_B];
        scr64[i] = b;
        s = {s[56:0], b};
      end
      scr64[121:64] = s;
    end
  endfunction

  // 32-bit header stream, bit 0 sent first
  function [31:0] sh_stream;
    input [25:0] p;
    input fec;
    input eoemb;
    begin
      if (fec)
        sh_stream = {1'b1, 4'h0, p[0], p[1], p[2], p[3], 1'b0, p[4], p[5], p[6], p[7],
                     p[8], p[9], p[10], p[11], p[12], p[13], p[14], p[15], p[16],
                     p[17], p[18], p[19], p[20], p[21], p[22], p[23], p[24], p[25]};
      else
        sh_stream = {1'b1, 4'h0, 3'h0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 3'h0, 1'b1,
                     p[0], p[1], p[2], 1'b1, p[3], p[4], p[5], 1'b1, p[6], p[7], p[8],
                     1'b1, p[9], p[10], p[11]};
      sh_stream[22] = eoemb;
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < `JLLA_LANES; g = g + 1) begin : lane
      wire [7:0] din = data_in[64*g +: 8];
      wire [63:0] bin = data_in[64*g +: 64];
      reg [14:0] s8_q;
      reg [57:0] s64_q;
      reg [7:0] prev_q;
      reg [25:0] par_q;
      reg [65:0] word_q;
      reg k_q;
      wire [22:0] s8_w = scr8(s8_q, din);
      wire [121:0] s64_w = scr64(s64_q, bin);
      wire [31:0] shs = sh_stream(par_q, fec_mode, emb_last);
      wire hb = shs[blk_q];
      wire [7:0] dsc = scr_en ? s8_w[7:0] : din;
      reg [7:0] oct_d;
      reg k_d;
      always @* begin
        oct_d = dsc;
        k_d = 1'b0;
        if (frm_end && scr_en) begin
          if (mf_end && dsc == `JLLA_D_A) begin
            oct_d = `JLLA_K_A;
            k_d = 1'b1;
          end else if (dsc == `JLLA_D_F) begin
            oct_d = `JLLA_K_F;
            k_d = 1'b1;
          end
        end else if (frm_end && din == prev_q) begin
          oct_d = mf_end ? `JLLA_K_A : `JLLA_K_F;
          k_d = 1'b1;
        end
      end
      always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          s8_q <= 15'h7fff;
          s64_q <= 58'h3ffffffffffffff;
          prev_q <= 8'h00;
          par_q <= 26'h0000000;
          word_q <= 66'h0;
          k_q <= 1'b0;
        end else if (mode_64b) begin
          s64_q <= s64_w[121:64];
          if (blk_last)
            par_q <= parity_in[26*g +: 26];
          word_q <= {s64_w[63:0], hb ? `JLLA_SH_ONE : `JLLA_SH_ZERO};
          k_q <= 1'b0;
        end else begin
          k_q <= 1'b1;
          word_q <= {58'h0, `JLLA_K_K};
          case (st_q)
            ST_ILAS: begin
              word_q <= {58'h0, ilas_oct};
              k_q <= ilas_k;
            end
            ST_DATA: begin
              if (scr_en)
                s8_q <= s8_w[22:8];
              if (frm_end)
                prev_q <= din;
              word_q <= {58'h0, oct_d};
              k_q <= k_d;
            end
            default: k_q <= 1'b1;
          endcase
        end
      end
      assign tx_word[66*g +: 66] = word_q;
      assign tx_k[g] = k_q;
    end
  endgenerate

  assign data_ready = mode_64b | (st_q == ST_DATA);
  assign mb_start = mode_64b & (blk_q == 5'h00);
  assign link_up = (st_q == ST_DATA);
endmodule
`default_nettype wire

// File: jlla_tx_asserts.sv
// assertions on the alignment transmitter ports
`timescale 1ns/1ps
`default_nettype none
`include "jlla_defines.vh"
module jlla_tx_asserts (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic sync_n,
  input wire logic sysref,
  input wire logic mode_64b,
  input wire logic [7:0] e_cfg,
  input wire logic [66*`JLLA_LANES-1:0] tx_word,
  input wire logic [`JLLA_LANES-1:0] tx_k,
  input wire logic mb_start,
  input wire logic link_up
);
  logic [3:0] rc_q;
  logic [3:0] sr_q;
  logic ok;
  // ok: reset synchronisers settled; sr_q: sysref effect window
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rc_q <= 4'h0;
      sr_q <= 4'h0;
    end else begin
      rc_q <= rc_q + {3'h0, rc_q != 4'hf};
      sr_q <= {sr_q[2:0], sysref};
    end
  end
  assign ok = rc_q == 4'hf;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_cgs_comma: assert property (
    (ok && !mode_64b && !sync_n) [*6] |-> tx_k[0] && tx_word[7:0] == 8'hbc)
    else $error("no comma");
  a_sync_abort: assert property ((!sync_n) [*5] |-> !link_up)
    else $error("link kept");
  a_data_entry: assert property ($rose(link_up) |-> (tx_k[0] && tx_word[7:0] == 8'h7c) ||
    ($past(tx_k[0]) && $past(tx_word[7:0]) == 8'h7c)) else $error("bad ilas end");
  a_hdr_split: assert property (
    ok && mode_64b |-> tx_word[1] != tx_word[0] && tx_word[67] != tx_word[66])
    else $error("bad header");
  a_k_none: assert property (ok && mode_64b |-> tx_k == 2'h0)
    else $error("k in 64b");
  a_mb_period: assert property (disable iff (!rst_b || sysref || sr_q != 4'h0)
    ok && mode_64b && mb_start |-> ##1 !mb_start ##31 mb_start) else $error("bad mb");
  a_pilot_end: assert property (
    ok && mode_64b && mb_start |-> ##28 !tx_word[1] [*4] ##1 tx_word[1])
    else $error("bad pilot");
  a_emb_mark: assert property (
    ok && mode_64b && mb_start && e_cfg == 8'h01 |-> ##23 tx_word[1])
    else $error("bad emb bit");
endmodule
bind jlla_tx jlla_tx_asserts u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .sync_n(sync_n),
  .sysref(sysref), .mode_64b(mode_64b), .e_cfg(e_cfg), .tx_word(tx_word), .tx_k(tx_k),
  .mb_start(mb_start), .link_up(link_up));
`default_nettype wire

// File: jlla_rx_model.sv
// receiver model that drives the sync request
`timescale 1ns/1ps
`default_nettype none
module jlla_rx_model (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic sysref,
  input wire logic [8:0] rx,
  input wire logic req,
  output logic sync_n
);
  logic [2:0] run_q;
  logic [4:0] lmfc_q;
  logic srf_q;
  // own multiframe counter, F*K = 18 octets
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      run_q <= 3'h0;
      sync_n <= 1'b0;
      lmfc_q <= 5'h00;
      srf_q <= 1'b0;
    end else begin
      srf_q <= sysref;
      if ((sysref && !srf_q) || lmfc_q == 5'h11)
        lmfc_q <= 5'h00;
      else
        lmfc_q <= lmfc_q + 5'h01;
      run_q <= (rx == 9'h1bc && !req) ? run_q + {2'h0, run_q != 3'h4} : 3'h0;
      sync_n <= !req && (sync_n || (run_q == 3'h4 && lmfc_q == 5'h11));
    end
  end
endmodule
`default_nettype wire

// File: tb_top.sv
// testbench for the alignment transmitter
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic sysref = 1'b0;
  logic mode_64b = 1'b0;
  logic req = 1'b0;
  logic scr_en = 1'b0;
  logic fec_mode = 1'b0;
  logic [127:0] data_in = 128'h0;
  logic [51:0] parity_in = 52'h0;
  logic [131:0] tx_word;
  logic [1:0] tx_k;
  logic sync_n;
  logic mb_start;
  logic link_up;
  integer n_fail = 0;
  integer checks = 0;
  integer cyc = 0;
  always #20 clk_sys = ~clk_sys;
  jlla_tx dut (.clk_sys(clk_sys), .rst_b(rst_b), .sync_n(sync_n), .sysref(sysref),
    .mode_64b(mode_64b), .scr_en(scr_en), .fec_mode(fec_mode), .f_cfg(9'h002), .k_cfg(9'h009),
    .e_cfg(8'h01), .cfg_params(112'h4d4c4b4a49484746454443424140), .data_in(data_in),
    .parity_in(parity_in), .data_ready(), .tx_word(tx_word), .tx_k(tx_k), .mb_start(mb_start),
    .link_up(link_up));
  jlla_rx_model u_rx (.clk_sys(clk_sys), .rst_b(rst_b), .sysref(sysref),
    .rx({tx_k[0], tx_word[7:0]}),
    .req(req), .sync_n(sync_n));
  function logic [31:0] lane(input integer g);
    lane = {23'h0, tx_k[g], tx_word[66*g+:8]};
  endfunction
  task end_sim;
    begin
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task cmp(input [95:0] nm, input [31:0] e, input [31:0] g);
    begin
      checks = checks + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("CHECK FAILED %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_fail = n_fail + 1;
      end_sim;
    end
  end
  task do_reset(input logic m);
    begin
      @(posedge clk_sys);
      rst_b <= 1'b0;
      mode_64b <= m;
      scr_en <= 1'b0;
      data_in <= {2{64'h55}};
      parity_in <= {2{26'h2b5c3e1}};
      repeat (5) @(posedge clk_sys);
      rst_b <= 1'b1;
      repeat (6) @(posedge clk_sys);
      sysref <= 1'b1;
      @(posedge clk_sys);
      sysref <= 1'b0;
    end
  endtask
  task t_cgs;
    begin
      @(posedge clk_sys);
      req <= 1'b1;
      repeat (8) @(negedge clk_sys);
      cmp("comma l0", 32'h1bc, lane(0));
      cmp("comma l1", 32'h1bc, lane(1));
      cmp("link down", 32'h0, {31'h0, link_up});
      @(posedge clk_sys);
      req <= 1'b0;
    end
  endtask
  task t_ilas;
    integer i;
    begin
      i = 0;
      @(negedge clk_sys);
      while (lane(0) !== 32'h11c && i < 400) begin
        @(negedge clk_sys);
        i = i + 1;
      end
      for (i = 0; i < 72; i = i + 1) begin
        if (i % 18 == 0)
          cmp("mf open", 32'h11c, lane(1));
        if (i % 18 == 17)
          cmp("mf close", 32'h17c, lane(1));
        if (i > 19 && i < 34)
          cmp("config", 32'h2c + i, lane(0));
        @(negedge clk_sys);
      end
      cmp("link up", 32'h1, {31'h0, link_up});
    end
  endtask
  task t_data;
    integer j;
    begin
      for (j = 0; j < 36; j = j + 1) begin
        if (j == 35)
          cmp("mf tail", 32'h17c, lane(0));
        else if (j > 17 && j % 2 == 1)
          cmp("frame tail", 32'h1fc, lane(0));
        else if (j > 17)
          cmp("raw octet", 32'h55, lane(0));
        @(negedge clk_sys);
      end
    end
  endtask
  task t_scr;
    integer j;
    logic e;
    begin
      @(posedge clk_sys);
      scr_en <= 1'b1;
      @(negedge clk_sys);
      for (j = 2; j < 38; j = j + 1) begin
        @(negedge clk_sys);
        // only frame ends may carry fc/7c as control characters
        e = (j % 2 == 1) && (tx_word[7:0] == 8'hfc || (j % 18 == 17 && tx_word[7:0] == 8'h7c));
        cmp("scr k", {31'h0, e}, {31'h0, tx_k[0]});
      end
    end
  endtask
  task t_64b(input logic f);
    integer i;
    logic [31:0] s;
    logic [31:0] x;
    begin
      i = 0;
      @(posedge clk_sys);
      fec_mode <= f;
      x = f ? {parity_in[25:4], 1'b1, parity_in[3:0], 5'h01} :
        {parity_in[11:9], 1'b1, parity_in[8:6], 1'b1, parity_in[5:3], 1'b1, parity_in[2:0],
         1'b1, 3'h0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 3'h0, 5'h01};
      repeat (70) @(negedge clk_sys);
      while (mb_start !== 1'b1 && i < 40) begin
        @(negedge clk_sys);
        i = i + 1;
      end
      repeat (2) begin
        s = 32'h0;
        for (i = 0; i < 32; i = i + 1) begin
          @(negedge clk_sys);
          s = {s[30:0], tx_word[1]};
        end
        cmp("hdr stream", x, s);
      end
    end
  endtask
  initial begin
    do_reset(1'b0);
    t_cgs;
    t_ilas;
    t_data;
    t_scr;
    t_cgs;
    t_ilas;
    do_reset(1'b1);
    t_64b(1'b1);
    t_64b(1'b0);
    end_sim;
  end
endmodule
`default_nettype wire
